/* rdi_rx_flags.sv */
// Receive event flags, their enables and the two summary interrupts.
// Assumes event inputs are synchronous to i_mclk and one cycle wide.
`timescale 1ns/1ps
`default_nettype none
`include "rdi_defines.svh"

// Contract
// - Bits 31:24 latch a per-buffer flag when a packet for that buffer aborts.
// - Bits 23:16 latch a per-buffer flag when a packet is confirmed there.
// - Bit 15 or 14 latches when stream B or A parity indicator changes.
// - Bit 13 or 12 latches when detected crypt mode differs from cipher setting.
// - Bit 11 or 10 latches on a video header steering error, B or A.
// - Bit 9 or 8 latches on a video sequence error, B or A.
// - Bit 7 is reserved, ignores writes and reads zero.
// - Bit 6 latches whenever a packet is answered with the busy code.
// - Bit 5 latches when a received payload check fails.
// - No valid buffer address aborts the packet and latches bit 4.
// - An illegal transaction code aborts the packet and latches bit 3.
// - Bit 2 latches when a packet is busied off for non-idle receivers.
// - Bit 1 latches on a quadlet write to the command-reset register.
// - Bit 0 latches when self-identification ends and all packets are stored.
// - Enables 31:16 route their flags to summary interrupt one.
// - Enable 15 routes the stream B parity flag to summary interrupt zero.
// - A cleared enable masks its flag; the flag still records events.
// - Enables 14 to 8 and 6 to 0 route their flags to summary interrupt zero.
// - Busy acknowledge uses code 4; busy-all beats tardy acknowledge.
module rdi_rx_flags (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rstn,
   // Register bus.
   input wire rdi_pkg::rdi_avs_req_t i_avs,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // Receive path events.
   input wire rdi_pkg::rdi_ev_t i_ev,
   input wire rdi_pkg::rdi_strm_t i_strm_a,
   input wire rdi_pkg::rdi_strm_t i_strm_b,
   // Acknowledge request.
   input wire logic i_ack_req,
   input wire logic [3:0] i_ack_code,
   output logic o_ack_valid,
   output logic [3:0] o_ack_code,
   output logic o_pkt_abort,
   // Summary interrupts.
   output logic o_irq_zero,
   output logic o_irq_one
);
   import rdi_pkg::*;

   // =====================================================
   // Helper functions.

   // Merges write data into an old word under byte enables.
   function automatic logic [31:0] rdi_merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] be
   );
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Compares a detected mode against the configured one.
   function automatic logic rdi_mis(input rdi_strm_t s);
      return s.mode_chk && (s.mode_det != s.mode_cfg);
   endfunction

   // =====================================================
   // Registers.
   logic [31:0] flags_ff;
   logic [31:0] nxt_flags;
   logic [31:0] en_ff;
   logic [31:0] nxt_en;
   logic [1:0] ctl_ff;
   logic [1:0] nxt_ctl;
   logic ack_ff;
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic prime_ff;
   logic par_a_ff;
   logic par_b_ff;
   logic ackv_ff;
   logic [3:0] ackc_ff;
   logic [3:0] nxt_ackc;
   logic abort_ff;
   logic irq0_ff;
   logic irq1_ff;

   // =====================================================
   // Bus decode.
   wire bus_req = i_avs.read | i_avs.write;
   wire bus_take = bus_req & ~ack_ff;
   wire hit_flags = (i_avs.address == `RDI_FLAGS_OFS);
   wire hit_en = (i_avs.address == `RDI_EN_OFS);
   wire hit_ctl = (i_avs.address == `RDI_CTL_OFS);
   wire wr_now = ack_ff & i_avs.write;
   wire clr_now = ack_ff & i_avs.read & hit_flags;
   wire [31:0] rd_val =
      hit_flags ? (flags_ff & ~`RDI_RSVD_MASK) :
      hit_en ? (en_ff & ~`RDI_RSVD_MASK) :
      hit_ctl ? {30'h0, ctl_ff} : 32'h0;

   // =====================================================
   // Event decode.
   wire par_chg_a = prime_ff & (i_strm_a.parity != par_a_ff);
   wire par_chg_b = prime_ff & (i_strm_b.parity != par_b_ff);
   wire mis_a = rdi_mis(i_strm_a);
   wire mis_b = rdi_mis(i_strm_b);
   wire busy_all = ctl_ff[`RDI_CTL_BUSY];
   wire tardy = ctl_ff[`RDI_CTL_TARDY];

   // Busy-all overrides tardy; with neither set the path's own code passes.
   assign nxt_ackc = busy_all ? `RDI_ACK_BUSY :
      tardy ? `RDI_ACK_TARDY : i_ack_code;
   wire busy_sent = i_ack_req & (nxt_ackc == `RDI_ACK_BUSY);
   wire pkt_abort = i_ev.no_target | i_ev.illegal_txn;

   // Hardware set vector in flag bit order.
   wire [31:0] hw_set = {
      i_ev.abort_buf,
      i_ev.done_buf,
      par_chg_b, par_chg_a,
      mis_b, mis_a,
      i_ev.steer_err_b, i_ev.steer_err_a,
      i_ev.order_err_b, i_ev.order_err_a,
      1'b0,
      busy_sent,
      i_ev.crc_fail,
      i_ev.no_target,
      i_ev.illegal_txn,
      i_ev.busied_off,
      i_ev.reset_cmd,
      i_ev.sid_done
   };

   // =====================================================
   // Next-state values.

   // Only bits actually returned by the read are cleared; set wins.
   wire [31:0] clr_mask = clr_now ? rdata_ff : 32'h0;
   assign nxt_flags = ((flags_ff & ~clr_mask) | hw_set)
      & ~`RDI_RSVD_MASK;
   wire [31:0] en_wr = rdi_merge(en_ff, i_avs.writedata, i_avs.byteenable);
   assign nxt_en = (wr_now & hit_en) ? (en_wr & ~`RDI_RSVD_MASK) : en_ff;
   wire [31:0] ctl_wr = rdi_merge({30'h0, ctl_ff}, i_avs.writedata,
      i_avs.byteenable);
   assign nxt_ctl = (wr_now & hit_ctl) ? ctl_wr[1:0] : ctl_ff;

   // Summaries follow the masked flags in the same cycle.
   wire nxt_irq1 = |(nxt_flags[`RDI_ONE_MSB:`RDI_ONE_LSB] &
      nxt_en[`RDI_ONE_MSB:`RDI_ONE_LSB]);
   wire nxt_irq0 = |(nxt_flags[`RDI_ZERO_MSB:0] &
      nxt_en[`RDI_ZERO_MSB:0]);

   // =====================================================
   // Bus handshake.
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         ack_ff <= 1'b0;
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0;
      end else begin
         ack_ff <= bus_take;
         wait_ff <= ~bus_take;
         if (bus_take & i_avs.read) begin
            rdata_ff <= rd_val;
         end
      end
   end

   // =====================================================
   // Register file.
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         flags_ff <= `RDI_FLAGS_RST;
         en_ff <= `RDI_EN_RST;
         ctl_ff <= `RDI_CTL_RST;
      end else begin
         flags_ff <= nxt_flags;
         en_ff <= nxt_en;
         ctl_ff <= nxt_ctl;
      end
   end

   // =====================================================
   // Parity indicator history.
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         prime_ff <= 1'b0;
         par_a_ff <= 1'b0;
         par_b_ff <= 1'b0;
      end else begin
         prime_ff <= 1'b1;
         par_a_ff <= i_strm_a.parity;
         par_b_ff <= i_strm_b.parity;
      end
   end

   // =====================================================
   // Acknowledge, abort and interrupt outputs.
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         ackv_ff <= 1'b0;
         ackc_ff <= 4'h0;
         abort_ff <= 1'b0;
         irq0_ff <= 1'b0;
         irq1_ff <= 1'b0;
      end else begin
         ackv_ff <= i_ack_req;
         ackc_ff <= i_ack_req ? nxt_ackc : ackc_ff;
         abort_ff <= pkt_abort;
         irq0_ff <= nxt_irq0;
         irq1_ff <= nxt_irq1;
      end
   end

   assign o_readdata = rdata_ff;
   assign o_waitrequest = wait_ff;
   assign o_ack_valid = ackv_ff;
   assign o_ack_code = ackc_ff;
   assign o_pkt_abort = abort_ff;
   assign o_irq_zero = irq0_ff;
   assign o_irq_one = irq1_ff;

   // =====================================================
   // Checks.
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   chk_abort_flag_set: assert property (
      i_ev.abort_buf[0] |=> flags_ff[24])
      else $error("Abort flag of buffer 0 not set.");

   chk_done_flag_set: assert property (
      i_ev.done_buf[7] |=> flags_ff[23])
      else $error("Done flag of buffer 7 not set.");

   chk_parity_toggle: assert property (
      prime_ff && (i_strm_b.parity != par_b_ff) |=> flags_ff[15])
      else $error("Stream B parity change not flagged.");

   chk_mode_mismatch: assert property (
      i_strm_a.mode_chk && (i_strm_a.mode_det != i_strm_a.mode_cfg)
      |=> flags_ff[12])
      else $error("Stream A mode mismatch not flagged.");

   chk_steer_err: assert property (
      i_ev.steer_err_b |=> flags_ff[11])
      else $error("Stream B steering error not flagged.");

   chk_order_err: assert property (
      i_ev.order_err_a |=> flags_ff[8])
      else $error("Stream A sequence error not flagged.");

   chk_rsvd_zero: assert property (
      !flags_ff[`RDI_RSVD_BIT] && !en_ff[`RDI_RSVD_BIT]
      && !o_readdata[`RDI_RSVD_BIT])
      else $error("Reserved bit is not zero.");

   chk_busy_ack_code: assert property (
      i_ack_req && busy_all |=> o_ack_valid
      && (o_ack_code == `RDI_ACK_BUSY) && flags_ff[6])
      else $error("Busy acknowledge not issued or flagged.");

   chk_tardy_ack: assert property (
      i_ack_req && !busy_all && tardy
      |=> o_ack_code == `RDI_ACK_TARDY)
      else $error("Tardy acknowledge code wrong.");

   chk_crc_flag: assert property (
      i_ev.crc_fail |=> flags_ff[5])
      else $error("Payload check failure not flagged.");

   chk_no_target: assert property (
      i_ev.no_target |=> o_pkt_abort && flags_ff[4])
      else $error("Missing buffer did not abort.");

   chk_illegal_txn: assert property (
      i_ev.illegal_txn |=> o_pkt_abort && flags_ff[3])
      else $error("Illegal code did not abort.");

   chk_busied_off: assert property (
      i_ev.busied_off |=> flags_ff[2])
      else $error("Busied-off packet not flagged.");

   chk_reset_cmd: assert property (
      i_ev.reset_cmd |=> flags_ff[1])
      else $error("Command reset not flagged.");

   chk_sid_done: assert property (
      i_ev.sid_done |=> flags_ff[0])
      else $error("Self-ID end not flagged.");

   chk_irq_one_or: assert property (
      o_irq_one == |(flags_ff[31:16] & en_ff[31:16]))
      else $error("Summary one disagrees with flags.");

   chk_irq_zero_b: assert property (
      flags_ff[15] && en_ff[15] |-> o_irq_zero)
      else $error("Stream B parity did not raise summary zero.");

   chk_irq_zero_or: assert property (
      o_irq_zero == |(flags_ff[15:0] & en_ff[15:0]))
      else $error("Summary zero disagrees with flags.");

   chk_mask_quiet: assert property (
      (en_ff == 32'h0) |-> !o_irq_zero && !o_irq_one)
      else $error("Masked flag reached a summary.");

   chk_read_clear: assert property (
      clr_now && (hw_set == 32'h0)
      |=> flags_ff == ($past(flags_ff) & ~$past(rdata_ff)))
      else $error("Status read did not clear flags.");

   chk_set_wins: assert property (
      clr_now && i_ev.sid_done |=> flags_ff[0])
      else $error("Set lost against clearing read.");

   chk_bus_answer: assert property (
      bus_take |=> !o_waitrequest ##1 o_waitrequest)
      else $error("Bus answer not one cycle after request.");

endmodule // rdi_rx_flags
`default_nettype wire

/* rdi_defines.svh */
// Offsets, reset values, field positions and codes of the receive event flags.
// Assumes a byte-addressed register bus with one 32-bit word per register.
`ifndef RDI_DEFINES_SVH
`define RDI_DEFINES_SVH
`define RDI_FLAGS_OFS 12'h348
`define RDI_EN_OFS 12'h34c
`define RDI_CTL_OFS 12'h350
`define RDI_FLAGS_RST 32'h0000_0000
`define RDI_EN_RST 32'h0000_0000
`define RDI_CTL_RST 2'h0
`define RDI_RSVD_BIT 7
`define RDI_RSVD_MASK 32'h0000_0080
`define RDI_ONE_MSB 31
`define RDI_ONE_LSB 16
`define RDI_ZERO_MSB 15
`define RDI_CTL_BUSY 0
`define RDI_CTL_TARDY 1
`define RDI_ACK_BUSY 4'h4
`define RDI_ACK_TARDY 4'hb
`endif

/* rdi_pkg.sv */
// Types shared by the receive event flag block and its surroundings.
// Assumes the receive path drives event strobes on the same clock.
package rdi_pkg;

   // =====================================================
   // Avalon-MM request from the bus master.
   typedef struct packed {
      logic read;
      logic write;
      logic [11:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } rdi_avs_req_t;

   // =====================================================
   // One-cycle event strobes from the receive path.
   typedef struct packed {
      logic [7:0] abort_buf;
      logic [7:0] done_buf;
      logic steer_err_b;
      logic steer_err_a;
      logic order_err_b;
      logic order_err_a;
      logic crc_fail;
      logic no_target;
      logic illegal_txn;
      logic busied_off;
      logic reset_cmd;
      logic sid_done;
   } rdi_ev_t;

   // =====================================================
   // Per-stream indicators.
   typedef struct packed {
      logic parity;
      logic mode_chk;
      logic [1:0] mode_det;
      logic [1:0] mode_cfg;
   } rdi_strm_t;

endpackage

/* rdi_rx_src.sv */
// Receive path stand-in that turns a fire request into one-cycle event strobes.
// Assumes the bench raises i_fire for one cycle with the chosen strobes on i_sel.
`timescale 1ns/1ps
`default_nettype none
module rdi_rx_src (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rstn,
   // Requests from the bench.
   input wire logic i_fire,
   input wire logic [25:0] i_sel,
   // Event strobes.
   output var rdi_pkg::rdi_ev_t o_ev
);
   import rdi_pkg::*;
   // ==========================================
   // Strobe register, low outside a fire request.
   rdi_ev_t ev_ff;
   always_ff @(posedge i_mclk) begin
      if (!i_rstn || !i_fire) begin
         ev_ff <= '0;
      end else begin
         ev_ff <= rdi_ev_t'(i_sel);
      end
   end
   assign o_ev = ev_ff;
endmodule // rdi_rx_src
`default_nettype wire

/* rx_datapath_interrupts_tb.sv */
// Self-checking bench for the receive event flags block.
// Assumes rdi_rx_src drives event strobes one cycle after a fire request.
`timescale 1ns/1ps
`default_nettype none
`include "rdi_defines.svh"
module rx_datapath_interrupts_tb;
   import rdi_pkg::*;
   logic i_mclk, i_rstn, fire, ack_req, waitreq, ack_valid, pkt_abort, irq0, irq1;
   logic [25:0] sel;
   logic [3:0] ack_in, ack_code, exp_code;
   logic [31:0] rd, q;
   rdi_avs_req_t avs;
   rdi_ev_t ev;
   rdi_strm_t st [2];
   int mismatches, cmp_count, cyc, i;
   // ==========================================
   // Clock, partner and design.
   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end
   rdi_rx_src u_src (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_fire(fire), .i_sel(sel), .o_ev(ev));
   rdi_rx_flags u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs(avs), .o_readdata(rd),
      .o_waitrequest(waitreq), .i_ev(ev), .i_strm_a(st[0]), .i_strm_b(st[1]),
      .i_ack_req(ack_req), .i_ack_code(ack_in), .o_ack_valid(ack_valid),
      .o_ack_code(ack_code), .o_pkt_abort(pkt_abort), .o_irq_zero(irq0), .o_irq_one(irq1));
   // ==========================================
   // Tasks.
   task automatic final_report();
      $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      avs <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
      do begin
         @(posedge i_mclk);
      end while (waitreq !== 1'b0);
      q = rd;
      avs <= '0;
   endtask
   task automatic pulse(input logic [25:0] v);
      @(posedge i_mclk);
      fire <= 1'b1;
      sel <= v;
      @(posedge i_mclk);
      fire <= 1'b0;
      @(posedge i_mclk);
      @(negedge i_mclk);
   endtask
   function automatic int fbit(input int k);
      if (k >= 10) begin
         return k + 6;
      end else if (k >= 6) begin
         return k + 2;
      end
      return k;
   endfunction
   // ==========================================
   // Timeout.
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end
   // ==========================================
   // Main sequence.
   initial begin
      i_rstn = 1'b0;
      fire = 1'b0;
      sel = '0;
      ack_req = 1'b0;
      ack_in = 4'h2;
      avs = '0;
      st[0] = '0;
      st[1] = '0;
      mismatches = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (5) @(posedge i_mclk);
      i_rstn <= 1'b1;
      bus(1'b0, `RDI_FLAGS_OFS, '0);
      chk("flags reset", q, `RDI_FLAGS_RST);
      bus(1'b0, `RDI_EN_OFS, '0);
      chk("enables reset", q, `RDI_EN_RST);
      bus(1'b1, `RDI_FLAGS_OFS, 32'hffff_ffff);
      bus(1'b0, `RDI_FLAGS_OFS, '0);
      chk("flags write", q, 32'h0);
      bus(1'b1, `RDI_EN_OFS, 32'hffff_ffff);
      bus(1'b0, `RDI_EN_OFS, '0);
      chk("enables", q, ~`RDI_RSVD_MASK);
      bus(1'b0, 12'h354, '0);
      chk("unmapped", q, 32'h0);
      $display("Test registers done");
      for (i = 0; i < 26; i++) begin
         pulse(26'h1 << i);
         chk("irq one", {31'h0, irq1}, {31'h0, fbit(i) >= 16});
         chk("irq zero", {31'h0, irq0}, {31'h0, fbit(i) < 16});
         chk("abort", {31'h0, pkt_abort}, {31'h0, fbit(i) inside {3, 4}});
         bus(1'b0, `RDI_FLAGS_OFS, '0);
         chk("event flag", q, 32'h1 << fbit(i));
         bus(1'b0, `RDI_FLAGS_OFS, '0);
         chk("cleared", q, 32'h0);
         @(negedge i_mclk);
         chk("irq idle", {30'h0, irq1, irq0}, 32'h0);
      end
      $display("Test events done");
      for (i = 0; i < 2; i++) begin
         @(posedge i_mclk);
         st[i].parity <= 1'b1;
         repeat (2) @(posedge i_mclk);
         @(negedge i_mclk);
         chk("parity irq", {31'h0, irq0}, 32'h1);
         bus(1'b0, `RDI_FLAGS_OFS, '0);
         chk("parity flag", q, 32'h1 << (14 + i));
         @(posedge i_mclk);
         st[i].mode_det <= 2'h2;
         st[i].mode_chk <= 1'b1;
         @(posedge i_mclk);
         st[i].mode_chk <= 1'b0;
         bus(1'b0, `RDI_FLAGS_OFS, '0);
         chk("mode flag", q, 32'h1 << (12 + i));
      end
      $display("Test streams done");
      // =====================================================
      // Event strobe lands on the very edge at which the read clears.
      pulse(26'h1);
      fork
         bus(1'b0, `RDI_FLAGS_OFS, '0);
         begin
            @(posedge i_mclk);
            fire <= 1'b1;
            sel <= 26'h1;
            @(posedge i_mclk);
            fire <= 1'b0;
         end
      join
      chk("set wins read", q, 32'h1);
      bus(1'b0, `RDI_FLAGS_OFS, '0);
      chk("set wins", q, 32'h1);
      bus(1'b0, `RDI_FLAGS_OFS, '0);
      chk("set wins cleared", q, 32'h0);
      $display("Test set wins done");
      bus(1'b1, `RDI_EN_OFS, 32'h0);
      pulse(26'h20);
      chk("masked irq", {31'h0, irq0}, 32'h0);
      bus(1'b0, `RDI_FLAGS_OFS, '0);
      chk("masked flag", q, 32'h20);
      $display("Test mask done");
      for (i = 0; i < 4; i++) begin
         bus(1'b1, `RDI_CTL_OFS, i);
         exp_code = i[0] ? 4'h4 : (i[1] ? `RDI_ACK_TARDY : ack_in);
         @(posedge i_mclk);
         ack_req <= 1'b1;
         @(posedge i_mclk);
         ack_req <= 1'b0;
         @(negedge i_mclk);
         chk("ack valid", {31'h0, ack_valid}, 32'h1);
         chk("ack code", {28'h0, ack_code}, {28'h0, exp_code});
         bus(1'b0, `RDI_FLAGS_OFS, '0);
         chk("busy flag", q, {25'h0, exp_code == 4'h4, 6'h0});
      end
      $display("Test acknowledge done");
      final_report();
   end
endmodule // rx_datapath_interrupts_tb
`default_nettype wire
